// [bench/pld_osc_model.sv]
// Behavioural oscillator and sampling detector facing the loop divider.
// Assumes one clock; pulses are launched by NBA at the rising edge.
module pld_osc_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [3:0]  gap,
	input  wire logic        sample_pulse,
	input  wire logic        divider_output_point,
	output logic             osc_pulse,
	output logic [15:0]      span,
	output logic [15:0]      hi_pulses,
	output logic [15:0]      n_samples
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0]  tick;
	logic [15:0] cnt;
	logic        acc;

	// A pulse only counts where the divider's enable lets it through.
	assign acc = osc_pulse & clk_en;

	// One single-cycle pulse every gap cycles; gap 1 is back to back.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick <= 4'h0;
			osc_pulse <= 1'b0;
		end
		else if (tick + 4'h1 >= gap)
		begin
			tick <= 4'h0;
			osc_pulse <= 1'b1;
		end
		else
		begin
			tick <= tick + 4'h1;
			osc_pulse <= 1'b0;
		end
	end

	// The detector measures pulses between samples and the output width.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 16'h0000;
			span <= 16'h0000;
			hi_pulses <= 16'h0000;
			n_samples <= 16'h0000;
		end
		else if (sample_pulse)
		begin
			span <= cnt;
			cnt <= {15'h0000, acc};
			hi_pulses <= {15'h0000, acc};
			n_samples <= n_samples + 16'h0001;
		end
		else
		begin
			cnt <= cnt + {15'h0000, acc};
			if (divider_output_point)
				hi_pulses <= hi_pulses + {15'h0000, acc};
		end
	end
endmodule // pld_osc_model

// [bench/tb_programmable_loop_divider.sv]
// Self-checking bench for the loop divider and its oscillator model.
// Assumes the divider counts from 00 after reset and samples the preset.
module tb_programmable_loop_divider;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 core_clk;
	logic                 rst_n;
	logic                 clk_en;
	logic [3:0]           gap;
	pld_pkg::pld_preset_t digits;
	logic                 sample_pulse;
	logic                 divider_output_point;
	logic                 osc_pulse;
	logic [15:0]          span;
	logic [15:0]          hi_pulses;
	logic [15:0]          n_samples;
	int                   miscompares;
	int                   n_tests;
	localparam logic [15:0] BASE = 16'(pld_pkg::DIV_BASE);
	localparam logic [15:0] DEAD = 16'(pld_pkg::DEAD_PULSES);

	pld_divider pld_divider_inst (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .osc_pulse(osc_pulse),
		.frequency_selection_digits(digits), .sample_pulse(sample_pulse),
		.divider_output_point(divider_output_point));
	pld_osc_model pld_osc_model_inst (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .gap(gap), .sample_pulse(sample_pulse),
		.divider_output_point(divider_output_point), .osc_pulse(osc_pulse),
		.span(span), .hi_pulses(hi_pulses), .n_samples(n_samples));

	// Free-running 250 MHz clock.
	always #2 core_clk = ~core_clk;

	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %0d seen %0d", name, exp, got);
			miscompares++;
		end
	endtask

	// Bounded wait for the next sample, then room for the dead pulses.
	task automatic wait_sample();
		logic [15:0] n0;
		int          i;
		n0 = n_samples;
		i = 0;
		while (n_samples === n0 && i < 4000)
		begin
			@(posedge core_clk);
			i++;
		end
		check("sample seen", 16'h0001, 16'(i < 4000));
		repeat (16) @(posedge core_clk);
	endtask

	task automatic t_reset();
		@(negedge core_clk);
		check("sample_pulse", 16'h0000, 16'(sample_pulse));
		check("output_point", 16'h0000, 16'(divider_output_point));
		wait_sample();
		check("first span", BASE - DEAD, span);
		check("output width", DEAD, hi_pulses);
	endtask

	task automatic t_zero();
		wait_sample();
		check("zero span", BASE, span);
		check("output width", DEAD, hi_pulses);
	endtask

	// Boundary and mid-range presets; each is changed only just after a sample.
	task automatic t_preset();
		logic [7:0]  p [4];
		logic [15:0] exp_span;
		p = '{8'h99, 8'h01, 8'h50, 8'h00};
		foreach (p[i])
		begin
			digits <= p[i];
			exp_span = BASE - (16'(p[i][7:4]) * 16'd10 + 16'(p[i][3:0]));
			wait_sample();
			wait_sample();
			check("preset span", exp_span, span);
		end
	endtask

	// Sparse pulses must give the same count in pulses.
	task automatic t_slow();
		gap <= 4'h3;
		wait_sample();
		wait_sample();
		check("slow span", BASE, span);
		check("slow width", DEAD, hi_pulses);
		gap <= 4'h1;
	endtask

	// Frozen pulses must not be counted, so the span stays whole.
	task automatic t_freeze();
		repeat (100) @(posedge core_clk);
		clk_en <= 1'b0;
		repeat (40) @(posedge core_clk);
		clk_en <= 1'b1;
		wait_sample();
		check("frozen span", BASE, span);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog well beyond the roughly 4800 cycles the run needs.
	initial
	begin
		#200000;
		miscompares++;
		$display("[FAIL] run time expected finish seen hang");
		summarize();
	end

	initial
	begin
		miscompares = 0;
		n_tests = 0;
		core_clk = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		gap = 4'h1;
		digits = 8'h00;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_zero();
		t_preset();
		t_slow();
		t_freeze();
		summarize();
	end
endmodule // tb_programmable_loop_divider

// [common/pld_pkg.sv]
// Constants and types shared by the programmable loop divider.
// Assumes one clock domain and an oscillator pulse already shaped
// to a single-cycle count enable by logic outside this block.
package pld_pkg;

	// Division base with an all-zero preset, and the target output rate.
	localparam int unsigned DIV_BASE     = 297;
	localparam int unsigned OUT_FREQ_KHZ = 100;

	// Input pulses spent reloading and rearming after the terminal pulse.
	localparam int unsigned DEAD_PULSES  = 3;

	// Decade layout: four BCD bits, highest legal digit, bit weights.
	localparam int unsigned DIGIT_W      = 4;
	localparam logic [3:0]  DIGIT_MAX    = 4'h9;
	localparam logic [3:0]  DIGIT_ZERO   = 4'h0;
	localparam int unsigned W1_BIT       = 0;
	localparam int unsigned W2_BIT       = 1;
	localparam int unsigned W8_BIT       = 3;

	// Legal range of the division base for a two-stage hundreds counter.
	localparam int unsigned DIV_BASE_MIN = 104;
	localparam int unsigned DIV_BASE_MAX = 402;

	// Width of the pulse-gap counter used by the checks.
	localparam int unsigned GAP_W        = 9;

	// Two-digit start count taken from the frequency selection digits.
	typedef struct packed {
		logic [3:0] tens;
		logic [3:0] units;
	} pld_preset_t;

	// Counting, then the three dead pulses after the terminal pulse.
	typedef enum logic [1:0] {
		PH_COUNT,
		PH_TERM,
		PH_RELEASE,
		PH_REARM
	} pld_phase_t;

endpackage

// [core/pld_divider.sv]
// Programmable divide-by-N loop divider, fully synchronous.
// Assumes osc_pulse is one core_clk cycle wide per oscillator period
// and that frequency_selection_digits hold still during a count cycle.
//
// What this block does
// [R1] With zero preset the divider divides input pulses by 297.
// [R2] Decades load a two-digit start count 00 to 99 from the digits.
// [R3] Reset leaves decades zero, stages low, terminal and reload clear.
// [R4] Pulses advance the units decade only while counting is gated on.
// [R5] Units decade carries into tens and exposes its weight-1, weight-2.
// [R6] Units bits reach the terminal flop only through the qualify gate.
// [R7] Tens decade clocks the first stage, feeds weight-1, weight-8 bits.
// [R8] Tens bits are ignored until the second stage sets at 200.
// [R9] First stage toggles only on a falling tens weight-8 bit.
// [R10] Tens rollover at 100 toggles the first stage.
// [R11] First stage falling toggles second stage, enabling qualify gate.
// [R12] The 294th pulse stops counting, sets reload flops, reloads preset.
// [R13] Rising reload flop b output makes the sampling pulse.
// [R14] Three dead pulses restart counting, spacing samples 297 minus preset apart.
// [R15] Nonzero preset keeps terminal 297, dividing by 297 minus preset.
// [R16] Each shaped pulse is a single-cycle enable, no ripple clocks.
// [R17] Controller keeps the preset digits stable between reloads.
module pld_divider #(
	parameter int unsigned DIVIDE_BASE = pld_pkg::DIV_BASE // [R1]
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	input  wire logic                 osc_pulse,
	input  wire pld_pkg::pld_preset_t frequency_selection_digits,
	output logic                      sample_pulse,
	output logic                      divider_output_point
);

	// Terminal sense count: the last pulse before the terminal one.
	localparam int unsigned SENSE = DIVIDE_BASE - pld_pkg::DEAD_PULSES - 1;
	localparam logic [3:0] SENSE_UNITS = 4'(SENSE % 10);
	localparam logic [3:0] SENSE_TENS  = 4'((SENSE / 10) % 10);
	localparam logic [1:0] SENSE_HUND  = 2'(SENSE / 100);

	// Refuse a base whose sense count the two binary stages cannot hold.
	if (DIVIDE_BASE < pld_pkg::DIV_BASE_MIN ||
	    DIVIDE_BASE > pld_pkg::DIV_BASE_MAX)
		$error("pld_divider: DIVIDE_BASE out of range");

	// Increment a BCD digit; anything at or above nine wraps to zero.
	function automatic logic [3:0] bcd_inc(input logic [3:0] d);
		return (d >= pld_pkg::DIGIT_MAX) ? pld_pkg::DIGIT_ZERO : d + 4'h1;
	endfunction

	// Numeric value of a two-digit preset.
	function automatic logic [8:0] bcd_value(input pld_pkg::pld_preset_t p);
		return 9'(p.tens) * 9'd10 + 9'(p.units);
	endfunction

	logic [3:0]          units_decade;
	logic [3:0]          tens_decade;
	logic                first_binary_stage;
	logic                second_binary_stage;
	logic                terminal_flop;
	logic                reload_flop_a;
	logic                reload_flop_b;
	pld_pkg::pld_phase_t phase;

	// Every shaped pulse is a plain enable in the core_clk domain.
	wire step          = clk_en & osc_pulse; // [R16]
	wire count_gate    = (phase == pld_pkg::PH_COUNT); // [R4]
	wire counted       = step & count_gate; // [R4]
	wire units_carry   = counted & (units_decade >= pld_pkg::DIGIT_MAX); // [R5]
	wire [3:0] next_tens = units_carry ? bcd_inc(tens_decade) : tens_decade;
	// Only a falling weight-8 bit clocks the first stage, as a rollover does.
	wire w8_fall       = tens_decade[pld_pkg::W8_BIT] &
	                     ~next_tens[pld_pkg::W8_BIT]; // [R7] [R9] [R10]
	wire first_fall    = w8_fall & first_binary_stage; // [R11]
	// Qualify gate sees the tens bits only once the hundreds stages match.
	wire terminal_qualify_gate = ({second_binary_stage, first_binary_stage}
	                     == SENSE_HUND) & (tens_decade == SENSE_TENS); // [R8]
	// Units bits reach the terminal flop only through the qualify gate.
	wire terminal_j    = terminal_qualify_gate &
	                     (units_decade == SENSE_UNITS); // [R6]
	wire terminal_event = counted & terminal_j; // [R12]

	// Phase steps once per pulse: terminal, then three dead pulses.
	pld_pkg::pld_phase_t next_phase;
	always_comb
	begin
		next_phase = phase;
		if (step)
		begin
			unique case (phase)
				pld_pkg::PH_COUNT:   if (terminal_j) next_phase = pld_pkg::PH_TERM;
				pld_pkg::PH_TERM:    next_phase = pld_pkg::PH_RELEASE;
				pld_pkg::PH_RELEASE: next_phase = pld_pkg::PH_REARM;
				pld_pkg::PH_REARM:   next_phase = pld_pkg::PH_COUNT; // [R14]
			endcase
		end
	end

	// Decades and binary stages; the terminal pulse reloads the preset.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			units_decade        <= 4'h0; // [R3]
			tens_decade         <= 4'h0;
			first_binary_stage  <= 1'b0;
			second_binary_stage <= 1'b0;
		end
		else if (terminal_event)
		begin
			units_decade        <= frequency_selection_digits.units; // [R2]
			tens_decade         <= frequency_selection_digits.tens; // [R15]
			first_binary_stage  <= 1'b0;
			second_binary_stage <= 1'b0;
		end
		else if (counted)
		begin
			units_decade <= bcd_inc(units_decade); // [R5]
			tens_decade  <= next_tens;
			if (w8_fall)
				first_binary_stage <= ~first_binary_stage; // [R10]
			if (first_fall)
				second_binary_stage <= ~second_binary_stage; // [R11]
		end
	end

	// Terminal and reload flops follow the phase; gate is off meanwhile.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase         <= pld_pkg::PH_COUNT;
			terminal_flop <= 1'b0; // [R3]
			reload_flop_a <= 1'b0;
			reload_flop_b <= 1'b0;
		end
		else
		begin
			phase         <= next_phase;
			terminal_flop <= (next_phase == pld_pkg::PH_TERM); // [R12]
			reload_flop_a <= (next_phase != pld_pkg::PH_COUNT) &&
			                 (next_phase != pld_pkg::PH_REARM);
			reload_flop_b <= (next_phase != pld_pkg::PH_COUNT);
		end
	end

	// Sample pulse marks the rising edge of reload flop b, one cycle long.
	// It is registered so it lines up with divider_output_point rising.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_pulse         <= 1'b0;
			divider_output_point <= 1'b0;
		end
		else
		begin
			sample_pulse <= terminal_event; // [R13]
			divider_output_point <= (next_phase != pld_pkg::PH_COUNT);
		end
	end

	// Check helpers: pulses seen between terminal events and the preset
	// that was loaded at the last one.
	logic [pld_pkg::GAP_W-1:0] gap;
	logic [8:0]                last_preset;
	logic                      seen_terminal;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap           <= '0;
			last_preset   <= '0;
			seen_terminal <= 1'b0;
		end
		else if (terminal_event)
		begin
			gap           <= '0;
			last_preset   <= bcd_value(frequency_selection_digits);
			seen_terminal <= 1'b1;
		end
		else if (step)
			gap <= gap + 9'd1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_GATE_HALT: assert property ( // [R4]
		!count_gate |=> $stable(units_decade) && $stable(tens_decade))
		else $error("decade moved while counting was gated off");
	AST_UNITS_CARRY: assert property ( // [R5]
		counted && !terminal_j && units_decade == 4'h9
		|=> units_decade == 4'h0 && tens_decade != $past(tens_decade))
		else $error("units rollover did not carry into tens");
	AST_NO_RISE_TOGGLE: assert property ( // [R9]
		counted && tens_decade == 4'h7 && units_decade == 4'h9
		|=> $stable(first_binary_stage))
		else $error("first stage toggled on a rising weight-8 bit");
	AST_ROLLOVER: assert property ( // [R10]
		counted && !terminal_j && tens_decade == 4'h9 && units_decade == 4'h9
		|=> first_binary_stage != $past(first_binary_stage))
		else $error("tens rollover did not toggle the first stage");
	AST_SECOND_STAGE: assert property ( // [R11]
		counted && !terminal_j && first_binary_stage &&
		tens_decade == 4'h9 && units_decade == 4'h9
		|=> second_binary_stage && !first_binary_stage)
		else $error("second stage did not set after first stage fell");
	AST_TERMINAL_QUAL: assert property ( // [R8]
		$rose(terminal_flop) |-> $past(second_binary_stage))
		else $error("terminal reached before second stage set");
	AST_RELOAD: assert property ( // [R12]
		terminal_event |=> terminal_flop && reload_flop_a && !count_gate
		&& units_decade == $past(frequency_selection_digits.units)
		&& tens_decade == $past(frequency_selection_digits.tens))
		else $error("terminal pulse did not stop and reload the count");
	AST_SAMPLE: assert property ( // [R13]
		$rose(divider_output_point) |-> sample_pulse ##1 !sample_pulse)
		else $error("sample pulse not tied to reload flop b rise");
	AST_PERIOD: assert property ( // [R14]
		terminal_event && seen_terminal
		|-> 9'(gap + 9'd1) == 9'(DIVIDE_BASE) - last_preset) // [R15]
		else $error("sampling pulses not spaced by base minus preset");
	// The gap helper counts pulses since the terminal one, so the dead
	// period is judged without looking at the phase register itself.
	AST_DEAD: assert property ( // [R14]
		seen_terminal && gap < 9'(pld_pkg::DEAD_PULSES) |-> !count_gate)
		else $error("counting restarted without dead pulses");
	AST_REARM: assert property ( // [R14]
		seen_terminal && gap == 9'(pld_pkg::DEAD_PULSES) |-> count_gate)
		else $error("counting did not restart after the dead pulses");

	COV_ZERO_PRESET: cover property (
		terminal_event && seen_terminal && last_preset == 9'd0);
	COV_MAX_PRESET: cover property (
		terminal_event && seen_terminal && last_preset == 9'd99);
	COV_REARM: cover property (
		phase == pld_pkg::PH_REARM && step ##1 count_gate);
	COV_FROZEN_PULSE: cover property (
		!clk_en && osc_pulse && count_gate);

endmodule // pld_divider
